//--- src/cprs_pkg.sv
// package for the command preset / ramp selector
// assumes signed 16-bit command words, full scale = +/-10000 (0.01 % units)
package cprs_pkg;
  // command word width and full scale
  localparam int CMD_W = 16;
  localparam logic signed [15:0] FULL_SCALE = 16'sh2710;
  // number of preset channels
  localparam int NUM_CH = 6;
  // cable-break hysteresis thresholds in microamps
  localparam logic [15:0] CUR_ON_UA = 16'h0ed8;
  localparam logic [15:0] CUR_OFF_UA = 16'h0e10;
  // ramp tick: one ramp step per millisecond
  localparam int TICK_US = 1000;
  localparam int CLK_MHZ = 40;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  // reset values
  localparam logic signed [15:0] RST_OUT = 16'sh0000;
  localparam logic RST_LOOP_OK = 1'b0;
  // combine modes
  typedef enum logic [0:0] {
    CPRS_PRIO = 1'b0,
    CPRS_ADD = 1'b1
  } cprs_comb_t;
  // ramp modes
  typedef enum logic [0:0] {
    CPRS_QUAD = 1'b0,
    CPRS_CHAN = 1'b1
  } cprs_ramp_t;
endpackage

//--- src/cprs_selector.sv
// command preset selection, ramp generator and cable-break status
// assumes rates/presets come from a nonvolatile parameter store outside,
// filled by the serial configuration link; recall pins are asynchronous
`timescale 1ns/100ps
// Contract
// - 4-20 mA line near zero forces output off
// - enable at 3.8 mA, disable below 3.6
// - cable_break_disable turns detection off
// - six recall inputs enable stored presets
// - recall_combine_select picks priority or additive
// - priority: lowest active channel number wins
// - priority: any active preset overrides external command
// - additive: sum all plus external, saturate
// - preset contributes only while recall asserted
// - ramp_mode_select applies in both combine modes
// - quadrant mode: four rates, channel rates ignored
// - ramp time spans min to max setting
// - channel mode: per-channel rate while on
// - channel mode: release rate after all off
// - channel additive: lowest active channel rate
// - status on cable break or processor fault
// - output proportional to conditioned command
// - parameters held in nonvolatile storage
// - parameters exchanged over serial null-modem link
module cprs_selector #(
  parameter int NCH = cprs_pkg::NUM_CH,
  parameter int TICK_CYCLES = cprs_pkg::TICK_CYC
) (
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  // command input (already digitised), current in microamps
  input wire logic signed [15:0] EXT_CMD,
  input wire logic [15:0] EXT_CURRENT_UA,
  input wire logic CURRENT_LOOP_MODE,
  // configuration from the parameter store, loaded over the serial link
  input wire logic CABLE_BREAK_DISABLE,
  input wire logic RECALL_COMBINE_SELECT,
  input wire logic RAMP_MODE_SELECT,
  input wire logic [NCH*16-1:0] PRESETS,
  input wire logic [63:0] QUADRANT_RAMP_RATES,
  input wire logic [NCH*16-1:0] CHANNEL_RAMP_RATES,
  input wire logic [15:0] RELEASE_RAMP_RATE,
  input wire logic [15:0] OUT_MIN,
  input wire logic [15:0] OUT_MAX,
  // recall pins and fault
  input wire logic [NCH-1:0] RECALL,
  input wire logic PROC_FAULT,
  // outputs
  output logic signed [15:0] CMD_OUT,
  output logic OUT_ENABLE,
  output logic STATUS
);

  // all state in one struct
  typedef struct packed {
    logic [NCH-1:0] rec_s1;   // first sync stage
    logic [NCH-1:0] rec_s2;   // second sync stage
    logic fault_s1;
    logic fault_s2;
    logic loop_ok;            // hysteresis state
    logic [31:0] tick_cnt;    // ms tick divider
    logic [31:0] acc;         // fractional ramp accumulator
    logic signed [15:0] out;  // ramped output
    logic out_en;
    logic status;
  } cprs_state_t;

  cprs_state_t st;
  cprs_state_t next_st;

  // combinational helpers
  logic signed [19:0] sum;        // wide sum for saturation
  logic signed [15:0] target;
  logic [15:0] rate_ms;           // active ramp time in ms
  logic [15:0] span;              // min..max span
  logic [31:0] step;              // step per tick
  logic any_on;
  logic break_now;
  int low_idx;
  logic [1:0] quad;

  // target selection and ramp rate
  always_comb
  begin
    sum = 20'(EXT_CMD);
    any_on = |st.rec_s2;
    low_idx = 0;
    target = EXT_CMD;
    // lowest active channel found by scanning down
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (st.rec_s2[i])
        low_idx = i;
    end
    // additive sum of active presets only
    for (int i = 0; i < NCH; i++)
    begin
      if (st.rec_s2[i])
        sum = sum + 20'(signed'(PRESETS[i*16 +: 16]));
    end
    if (RECALL_COMBINE_SELECT == cprs_pkg::CPRS_ADD)
    begin
      // clamp to full scale either way
      if (sum > 20'(cprs_pkg::FULL_SCALE))
        target = cprs_pkg::FULL_SCALE;
      else if (sum < -20'(cprs_pkg::FULL_SCALE))
        target = -cprs_pkg::FULL_SCALE;
      else
        target = sum[15:0];
    end
    else if (any_on)
      target = signed'(PRESETS[low_idx*16 +: 16]);
    // quadrant: bit1 = negative side, bit0 = falling magnitude
    quad[1] = (target < 0) || (target == 0 && st.out < 0);
    quad[0] = quad[1] ? (target > st.out) : (target < st.out);
    if (RAMP_MODE_SELECT == cprs_pkg::CPRS_QUAD)
      rate_ms = QUADRANT_RAMP_RATES[quad*16 +: 16];
    else if (any_on)
      rate_ms = CHANNEL_RAMP_RATES[low_idx*16 +: 16];
    else
      rate_ms = RELEASE_RAMP_RATE;
    // span between min and max settings
    span = (OUT_MAX > OUT_MIN) ? OUT_MAX - OUT_MIN : 16'h0001;
    // zero ramp time means jump straight to target
    step = (rate_ms == 16'h0000) ? 32'hffff_ffff :
      ({16'h0000, span} << 16) / {16'h0000, rate_ms};
  end

  // next-state logic
  always_comb
  begin
    next_st = st;
    next_st.rec_s1 = RECALL;
    next_st.rec_s2 = st.rec_s1;
    next_st.fault_s1 = PROC_FAULT;
    next_st.fault_s2 = st.fault_s1;
    // hysteresis on loop current
    if (EXT_CURRENT_UA >= cprs_pkg::CUR_ON_UA)
      next_st.loop_ok = 1'b1;
    else if (EXT_CURRENT_UA < cprs_pkg::CUR_OFF_UA)
      next_st.loop_ok = 1'b0;
    // break only counts in 4-20 mA mode with detection on
    // uses the new hysteresis state so the enable follows the current in one cycle
    break_now = CURRENT_LOOP_MODE && !CABLE_BREAK_DISABLE && !next_st.loop_ok;
    next_st.out_en = !break_now;
    next_st.status = break_now || st.fault_s2;
    // ramp tick divider
    if (st.tick_cnt >= 32'(TICK_CYCLES - 1))
    begin
      next_st.tick_cnt = 32'h0000_0000;
      // accumulate fractional steps, whole units in upper half
      next_st.acc = st.acc + step;
      if (step == 32'hffff_ffff || 32'(st.acc[31:16]) >=
          32'(target > st.out ? target - st.out : st.out - target))
      begin
        next_st.out = target;
        next_st.acc = 32'h0000_0000;
      end
      else if (target > st.out)
      begin
        next_st.out = st.out + signed'(next_st.acc[31:16]);
        next_st.acc = {16'h0000, next_st.acc[15:0]};
      end
      else if (target < st.out)
      begin
        next_st.out = st.out - signed'(next_st.acc[31:16]);
        next_st.acc = {16'h0000, next_st.acc[15:0]};
      end
    end
    else
      next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
  end

  // register, frozen while CE is low
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      st <= '0;
      st.out <= cprs_pkg::RST_OUT;
      st.loop_ok <= cprs_pkg::RST_LOOP_OK;
    end
    else if (CE)
      st <= next_st;
  end

  // outputs from flip-flops; output forced to zero when disabled
  assign CMD_OUT = st.out_en ? st.out : 16'sh0000;
  assign OUT_ENABLE = st.out_en;
  assign STATUS = st.status;

endmodule

//--- dv/cprs_monitor.sv
// output checker for the selector, bound onto it
// assumes the tick parameter is handed on by the bind
`timescale 1ns/100ps
module cprs_monitor #(parameter int TICK_CYCLES = 4) (
  // clock, reset and watched inputs
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [15:0] EXT_CURRENT_UA,
  input wire logic CURRENT_LOOP_MODE,
  input wire logic CABLE_BREAK_DISABLE,
  input wire logic PROC_FAULT,
  // outputs
  input wire logic signed [15:0] CMD_OUT,
  input wire logic OUT_ENABLE,
  input wire logic STATUS
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  logic [15:0] gap; // cycles since the last ramp step
  wire logic armed = CE && CURRENT_LOOP_MODE && !CABLE_BREAK_DISABLE; // detection live
  // step spacing; enable edges zero the output, so they do not count
  always_ff @(posedge CLOCK or posedge RST)
    if (RST)
      gap <= 16'hffff;
    else if ($changed(CMD_OUT) && OUT_ENABLE && $stable(OUT_ENABLE))
      gap <= 16'h0000;
    else if (CE && gap != 16'hffff)
      gap <= gap + 16'h0001;
  sequence s_low; armed && EXT_CURRENT_UA < cprs_pkg::CUR_OFF_UA; endsequence
  sequence s_fault; (CE && PROC_FAULT)[*3]; endsequence
  sequence s_quiet; (CE && !CURRENT_LOOP_MODE && !PROC_FAULT)[*4]; endsequence
  property p_off; s_low |=> !OUT_ENABLE && STATUS; endproperty
  a_off: assert property (p_off) else $error("broken loop not reported");
  property p_on; CE && (!armed || EXT_CURRENT_UA >= cprs_pkg::CUR_ON_UA) |=> OUT_ENABLE; endproperty
  a_on: assert property (p_on) else $error("output not enabled");
  property p_band; armed && EXT_CURRENT_UA >= cprs_pkg::CUR_OFF_UA &&
    EXT_CURRENT_UA < cprs_pkg::CUR_ON_UA |=> $stable(OUT_ENABLE); endproperty
  a_band: assert property (p_band) else $error("enable moved in band");
  property p_zero; !OUT_ENABLE |-> CMD_OUT == 16'sh0000; endproperty
  a_zero: assert property (p_zero) else $error("command while off");
  property p_fault; s_fault |=> STATUS; endproperty
  a_fault: assert property (p_fault) else $error("fault not reported");
  property p_clear; s_quiet |=> !STATUS; endproperty
  a_clear: assert property (p_clear) else $error("status stuck");
  property p_sat; CMD_OUT <= cprs_pkg::FULL_SCALE && CMD_OUT >= -cprs_pkg::FULL_SCALE; endproperty
  a_sat: assert property (p_sat) else $error("command past full scale");
  property p_tick; $changed(CMD_OUT) && OUT_ENABLE && $stable(OUT_ENABLE) |->
    gap >= TICK_CYCLES - 1; endproperty
  a_tick: assert property (p_tick) else $error("ramp step off tick");
endmodule
bind cprs_selector cprs_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.CLOCK, .RST, .CE,
  .EXT_CURRENT_UA, .CURRENT_LOOP_MODE, .CABLE_BREAK_DISABLE, .PROC_FAULT, .CMD_OUT,
  .OUT_ENABLE, .STATUS);

//--- dv/cprs_partner.sv
// control-system stand-in: rate table and recall pins
// assumes requests change at the falling clock edge
`timescale 1ns/100ps
module cprs_partner (
  // clock and requests
  input wire logic CLOCK,
  input wire logic [5:0] WANT,
  input wire logic CHAN_MODE,
  // to the selector
  output logic [5:0] RECALL,
  output logic [63:0] QRATES,
  output logic [95:0] CRATES,
  output logic [15:0] RRATE
);
  // slow rates only on the set that must be ignored, so a wrong pick shows
  assign QRATES = {4{CHAN_MODE ? 16'h03e8 : 16'h0000}};
  assign CRATES = {6{CHAN_MODE ? 16'h0000 : 16'h03e8}};
  assign RRATE = CHAN_MODE ? 16'h0000 : 16'h03e8;
  initial RECALL = 6'h00;
  // pins follow requests off the sampling edge
  always @(negedge CLOCK)
    RECALL <= WANT;
endmodule

//--- dv/cprs_selector_test.sv
// self-checking bench for the preset/ramp selector
// assumes a 4-cycle tick, so every jump lands within twelve cycles
`timescale 1ns/100ps
module cprs_selector_test;
  logic clock = 1'b0, rst = 1'b1, loop = 1'b0, cbd = 1'b0, comb = 1'b0, ramp = 1'b0;
  logic fault = 1'b0, chk = 1'b0, hit;
  logic signed [15:0] ext = 16'sh0000, p, pr;
  logic [15:0] cur = 16'h0000, rr;
  logic [95:0] pre = '0, cr;
  logic [63:0] qr;
  logic [5:0] want = 6'h00, rcl;
  logic [15:0] tab[5] = '{16'h0bb8, 16'h0e74, 16'h0ed8, 16'h0e74, 16'h0e0f}; // loop currents
  wire logic signed [15:0] cmd;
  wire logic en, st;
  logic [17:0] notes[$]; // expected command, enable, status
  int errors = 0, n_checks = 0, cycles = 0, s;
  initial forever #12.5 clock = ~clock;
  cprs_partner ctl (.CLOCK(clock), .WANT(want), .CHAN_MODE(ramp), .RECALL(rcl), .QRATES(qr),
    .CRATES(cr), .RRATE(rr));
  cprs_selector #(.TICK_CYCLES(4)) dut (.CLOCK(clock), .RST(rst), .CE(1'b1), .EXT_CMD(ext),
    .EXT_CURRENT_UA(cur), .CURRENT_LOOP_MODE(loop), .CABLE_BREAK_DISABLE(cbd),
    .RECALL_COMBINE_SELECT(comb), .RAMP_MODE_SELECT(ramp), .PRESETS(pre),
    .QUADRANT_RAMP_RATES(qr), .CHANNEL_RAMP_RATES(cr), .RELEASE_RAMP_RATE(rr),
    .OUT_MIN(16'h0000), .OUT_MAX(16'h2710), .RECALL(rcl), .PROC_FAULT(fault),
    .CMD_OUT(cmd), .OUT_ENABLE(en), .STATUS(st));
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // note the result, let it settle, then flag the watcher
  task automatic expect_out(input logic [17:0] e);
    notes.push_back(e);
    repeat (12) @(negedge clock);
    chk = 1'b1;
    @(negedge clock);
    chk = 1'b0;
  endtask
  // watcher, with the hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (chk)
      cmp({cmd, en, st}, notes.pop_front());
    if (cycles == 5000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    s = $urandom(32'h33742cdc);
    repeat (12) @(negedge clock);
    rst = 1'b0;
    // random recalls in all four mode pairs; every sixth trial releases all
    for (int i = 0; i < 24; i++)
    begin
      comb = i[0];
      ramp = i[1];
      want = (i % 6 == 5) ? 6'h00 : 6'($urandom);
      ext = 16'($urandom_range(20000) - 10000);
      s = ext;
      hit = 1'b0;
      for (int c = 0; c < 6; c++)
      begin
        p = 16'($urandom_range(20000) - 10000);
        pre[16*c +: 16] = p;
        s += want[c] ? int'(p) : 0;
        pr = (want[c] && !hit) ? p : pr;
        hit |= want[c];
      end
      s = comb ? (s > 10000 ? 10000 : (s < -10000 ? -10000 : s)) : (hit ? pr : ext);
      expect_out({16'(s), 2'b10});
    end
    // hysteresis walk through the loop-current table
    loop = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      cur = tab[k];
      expect_out({(k == 2 || k == 3) ? ext : 16'sh0000, k == 2 || k == 3, k < 2 || k == 4});
    end
    cbd = 1'b1;
    expect_out({ext, 2'b10});
    fault = 1'b1;
    expect_out({ext, 2'b11});
    finish_test();
  end
endmodule
